// *** logic/sws_pkg.sv ***
package sws_pkg;
  localparam logic [18:0] FLAGS_ADDR = 19'h7FFF0;
  localparam logic [18:0] WD_ADDR = 19'h7FFF7;
  localparam logic [18:0] CTRL_ADDR = 19'h7FFF8;
  localparam logic [18:0] ALARM_MON_ADDR = 19'h7FFF6;
  localparam logic [18:0] DAY_ADDR = 19'h7FFFC;
  localparam logic [18:0] SEC_ADDR = 19'h7FFF9;
  localparam int FLAG_WDF_BIT = 7;
  localparam int WD_STEER_BIT = 7;
  localparam int AFE_BIT = 7;
  localparam int SQUARE_WAVE_ENABLE_BIT = 6;
  localparam int ABE_BIT = 5;
  localparam int FT_BIT = 6;
  localparam int ST_BIT = 7;
  localparam int CAL_SIGN_BIT = 5;
  localparam int CLK_HZ = 50000000;
  localparam int OSC_HZ = 32768;
  localparam int FAST_RST_MIN_NS = 50;
  localparam int SLOW_RST_MIN_MS = 20;
  localparam int REC_MIN_MS = 40;
  localparam int FAST_RST_CYC = (FAST_RST_MIN_NS * 50 + 999) / 1000;
  localparam int SLOW_RST_CYC = SLOW_RST_MIN_MS * (CLK_HZ / 1000);
  localparam int REC_CYC = REC_MIN_MS * (CLK_HZ / 1000);
  localparam int OSC_DIV = CLK_HZ / (2 * OSC_HZ);
  localparam int OSC_PER_MIN = OSC_HZ * 60;
  localparam int CAL_CYCLE_MIN = 64;
  localparam int CAL_LAST_MIN = 62;
  localparam int CAL_SHORT = 128;
  localparam int CAL_LONG = 256;
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sws_bus_type;
endpackage

// *** logic/sws_top.sv ***
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module sws_top #(
  parameter int SLOW_CYC = sws_pkg::SLOW_RST_CYC,
  parameter int REC_CYC_P = sws_pkg::REC_CYC,
  parameter int SIXTEENTH_OSC = sws_pkg::OSC_HZ / 16,
  parameter int MIN_OSC = sws_pkg::OSC_PER_MIN
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire sws_pkg::sws_bus_type i_bus,
  input wire logic i_power_fail,
  input wire logic i_alarm_irq,
  input wire logic i_alarm_flag,
  input wire logic i_battery_low,
  input wire logic i_watchdog_kick_input,
  input wire logic i_fast_reset_input_n,
  input wire logic i_slow_reset_input_n,
  output logic [7:0] o_rdata,
  output logic o_irq_test_oe,
  output logic o_reset_oe,
  output logic o_square_wave_pin,
  output logic o_square_wave_oe,
  output logic o_second_tick
);
  import sws_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] wd_reg, ctrl_reg;
  logic [3:0] rate_reg;
  logic afe_reg, square_wave_enable_reg, abe_reg, ft_reg, st_reg, wdf_reg;
  logic [10:0] osc_div_reg;
  logic osc_tick;
  logic [14:0] osc_cnt_reg;
  logic [31:0] wd_cnt_reg;
  logic [31:0] wd_limit;
  logic wd_irq_reg, kick_reg, timeout;
  logic [18:0] last_addr_reg;
  logic [7:0] flags_snap_reg;
  logic [31:0] fast_cnt_reg, slow_cnt_reg, rec_cnt_reg;
  logic rst_req, rst_hold_reg;
  logic [16:0] sec_cnt_reg;
  logic [5:0] sec_of_min_reg, min_cnt_reg;
  logic wr_wd, rd_flags, cal_active;
  logic [16:0] sec_len;
  assign wr_wd = i_bus.wr && i_bus.addr == WD_ADDR;
  assign rd_flags = i_bus.rd && i_bus.addr == FLAGS_ADDR;
  // Oscillator edges at 32768 Hz
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_div_reg <= 11'h000;
      osc_tick <= 1'b0;
    end else if (st_reg) begin
      osc_tick <= 1'b0;
    end else if (osc_div_reg == 11'(2 * OSC_DIV - 1)) begin
      osc_div_reg <= 11'h000;
      osc_tick <= 1'b1;
    end else begin
      osc_div_reg <= osc_div_reg + 11'h001;
      osc_tick <= 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) osc_cnt_reg <= 15'h0000;
    else if (osc_tick) osc_cnt_reg <= osc_cnt_reg + 15'h0001;
  end
  // Watchdog limit in oscillator cycles
  always_comb begin
    case (wd_reg[1:0])
      2'b00: wd_limit = 32'(wd_reg[6:2]) * 32'(SIXTEENTH_OSC);
      2'b01: wd_limit = 32'(wd_reg[6:2]) * 32'(SIXTEENTH_OSC * 4);
      2'b10: wd_limit = 32'(wd_reg[6:2]) * 32'(SIXTEENTH_OSC * 16);
      default: wd_limit = 32'(wd_reg[6:2]) * 32'(SIXTEENTH_OSC * 64);
    endcase
  end
  assign timeout = osc_tick && wd_limit != 32'h0 && !wd_irq_reg
    && wd_cnt_reg + 32'h1 >= wd_limit;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) kick_reg <= 1'b0;
    else kick_reg <= i_watchdog_kick_input;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) wd_cnt_reg <= 32'h0;
    else if (wr_wd || kick_reg != i_watchdog_kick_input || timeout)
      wd_cnt_reg <= 32'h0;
    else if (osc_tick) wd_cnt_reg <= wd_cnt_reg + 32'h1;
  end
  // Registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_reg <= 8'h00;
      ctrl_reg <= 8'h00;
      rate_reg <= 4'h0;
      afe_reg <= 1'b0;
      square_wave_enable_reg <= 1'b0;
      abe_reg <= 1'b0;
      ft_reg <= 1'b0;
      st_reg <= 1'b0;
    end else if (i_power_fail) begin
      wd_reg <= 8'h00;
      ft_reg <= 1'b0;
    end else if (timeout && wd_reg[WD_STEER_BIT]) begin
      wd_reg <= 8'h00;
      afe_reg <= 1'b0;
      square_wave_enable_reg <= 1'b0;
      abe_reg <= 1'b0;
      ft_reg <= 1'b0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == WD_ADDR) wd_reg <= i_bus.wdata;
      if (i_bus.addr == CTRL_ADDR) ctrl_reg <= i_bus.wdata;
      if (i_bus.addr == FLAGS_ADDR) rate_reg <= i_bus.wdata[3:0];
      if (i_bus.addr == ALARM_MON_ADDR) begin
        afe_reg <= i_bus.wdata[AFE_BIT];
        square_wave_enable_reg <= i_bus.wdata[SQUARE_WAVE_ENABLE_BIT];
        abe_reg <= i_bus.wdata[ABE_BIT];
      end
      if (i_bus.addr == DAY_ADDR) ft_reg <= i_bus.wdata[FT_BIT];
      if (i_bus.addr == SEC_ADDR) st_reg <= i_bus.wdata[ST_BIT];
    end
  end
  // Watchdog flag, set wins over read clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) wdf_reg <= 1'b0;
    else if (timeout) wdf_reg <= 1'b1;
    else if (rd_flags) wdf_reg <= 1'b0;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) wd_irq_reg <= 1'b0;
    else if (timeout && !wd_reg[WD_STEER_BIT]) wd_irq_reg <= 1'b1;
    else if (wr_wd && i_bus.wdata == 8'h00) wd_irq_reg <= 1'b0;
  end
  // Flags snapshot refreshed only on address change
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      last_addr_reg <= 19'h00000;
      flags_snap_reg <= 8'h00;
    end else if (i_bus.rd) begin
      last_addr_reg <= i_bus.addr;
      if (i_bus.addr != last_addr_reg)
        flags_snap_reg <= {wdf_reg, i_alarm_flag, 1'b0, i_battery_low,
          rate_reg};
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) o_rdata <= 8'h00;
    else if (!i_bus.rd) o_rdata <= 8'h00;
    else if (i_bus.addr == FLAGS_ADDR)
      o_rdata <= (i_bus.addr != last_addr_reg) ? {wdf_reg, i_alarm_flag,
        1'b0, i_battery_low, rate_reg} : flags_snap_reg;
    else if (i_bus.addr == WD_ADDR) o_rdata <= wd_reg;
    else if (i_bus.addr == CTRL_ADDR) o_rdata <= ctrl_reg;
    else o_rdata <= 8'h00;
  end
  // Reset input qualification
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) fast_cnt_reg <= 32'h0;
    else if (i_fast_reset_input_n) fast_cnt_reg <= 32'h0;
    else if (fast_cnt_reg < 32'(FAST_RST_CYC))
      fast_cnt_reg <= fast_cnt_reg + 32'h1;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) slow_cnt_reg <= 32'h0;
    else if (i_slow_reset_input_n) slow_cnt_reg <= 32'h0;
    else if (slow_cnt_reg < 32'(SLOW_CYC))
      slow_cnt_reg <= slow_cnt_reg + 32'h1;
  end
  assign rst_req = i_power_fail || fast_cnt_reg >= 32'(FAST_RST_CYC)
    || slow_cnt_reg >= 32'(SLOW_CYC);
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rec_cnt_reg <= 32'h0;
      rst_hold_reg <= 1'b0;
    end else if (rst_req || (timeout && wd_reg[WD_STEER_BIT])) begin
      rec_cnt_reg <= 32'(REC_CYC_P);
      rst_hold_reg <= 1'b1;
    end else if (rec_cnt_reg > 32'h1) begin
      rec_cnt_reg <= rec_cnt_reg - 32'h1;
    end else begin
      rec_cnt_reg <= 32'h0;
      rst_hold_reg <= 1'b0;
    end
  end
  assign o_reset_oe = rst_hold_reg;
  // Calibrated second, minute counters
  assign cal_active = min_cnt_reg < 6'(2 * ctrl_reg[4:0])
    && min_cnt_reg < 6'(CAL_LAST_MIN) && sec_of_min_reg == 6'h00;
  always_comb begin
    sec_len = 17'(OSC_HZ);
    if (cal_active) begin
      if (ctrl_reg[CAL_SIGN_BIT]) sec_len = 17'(OSC_HZ - CAL_SHORT);
      else sec_len = 17'(OSC_HZ + CAL_LONG);
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sec_cnt_reg <= 17'h00000;
      sec_of_min_reg <= 6'h00;
      min_cnt_reg <= 6'h00;
      o_second_tick <= 1'b0;
    end else begin
      o_second_tick <= 1'b0;
      if (osc_tick) begin
        if (sec_cnt_reg + 17'h1 >= sec_len) begin
          sec_cnt_reg <= 17'h00000;
          o_second_tick <= 1'b1;
          if (sec_of_min_reg == 6'd59) begin
            sec_of_min_reg <= 6'h00;
            min_cnt_reg <= min_cnt_reg + 6'h01;
          end else sec_of_min_reg <= sec_of_min_reg + 6'h01;
        end else sec_cnt_reg <= sec_cnt_reg + 17'h00001;
      end
    end
  end
  // Square wave and test pin, from raw divider
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_square_wave_pin <= 1'b0;
      o_square_wave_oe <= 1'b0;
    end else begin
      o_square_wave_oe <= square_wave_enable_reg && rate_reg != 4'h0;
      if (rate_reg == 4'h0) o_square_wave_pin <= 1'b0;
      else if (rate_reg == 4'h1)
        o_square_wave_pin <= osc_div_reg < 11'(OSC_DIV);
      else o_square_wave_pin <= osc_cnt_reg[rate_reg - 4'h1];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) o_irq_test_oe <= 1'b0;
    else if (wd_irq_reg || i_alarm_irq) o_irq_test_oe <= 1'b1;
    else if (!st_reg && ft_reg && !afe_reg
      && (wd_reg[WD_STEER_BIT] || wd_reg == 8'h00))
      o_irq_test_oe <= !osc_cnt_reg[5];
    else o_irq_test_oe <= 1'b0;
  end
  // Watchdog expiry, split by steering
  sequence s_wd_irq_expire;
    timeout && !wd_reg[WD_STEER_BIT];
  endsequence
  sequence s_wd_rst_expire;
    timeout && wd_reg[WD_STEER_BIT];
  endsequence
  a_wdf_set: assert property (
    timeout |=> wdf_reg)
    else $error("flag not set");
  a_wdf_clear: assert property (
    rd_flags && !timeout |=> !wdf_reg)
    else $error("flag kept");
  a_irq_drive: assert property (
    s_wd_irq_expire |=> ##1 o_irq_test_oe)
    else $error("irq missing");
  a_wd_pulse: assert property (
    s_wd_rst_expire |=> o_reset_oe)
    else $error("watchdog reset missing");
  a_wd_clear: assert property (
    s_wd_rst_expire |=> wd_reg == 8'h00 && !ft_reg)
    else $error("wd not cleared");
  a_wd_enables: assert property (
    timeout && wd_reg[WD_STEER_BIT] && !i_power_fail
      |=> !afe_reg && !square_wave_enable_reg && !abe_reg)
    else $error("enables not cleared");
  a_kick_rst: assert property (
    wr_wd |=> wd_cnt_reg == 32'h0)
    else $error("no restart");
  a_kick_edge: assert property (
    kick_reg != i_watchdog_kick_input |=> wd_cnt_reg == 32'h0)
    else $error("kick edge ignored");
  a_cnt_bound: assert property (
    wd_limit != 32'h0 && !wd_irq_reg |-> wd_cnt_reg < wd_limit)
    else $error("count beyond limit");
  a_limit_zero: assert property (
    wd_reg[6:2] == 5'h00 |-> wd_limit == 32'h0)
    else $error("zero multiplier not idle");
  a_irq_rel: assert property (
    wr_wd && i_bus.wdata == 8'h00 && !timeout |=> !wd_irq_reg)
    else $error("irq kept");
  a_irq_hold: assert property (
    wd_irq_reg && !(wr_wd && i_bus.wdata == 8'h00) |=> wd_irq_reg)
    else $error("irq dropped early");
  a_irq_halt: assert property (
    wd_irq_reg |-> !timeout)
    else $error("timeout while halted");
  a_pf_clear: assert property (
    i_power_fail |=> wd_reg == 8'h00 ##1 o_reset_oe)
    else $error("pf");
  a_pf_ft: assert property (
    i_power_fail |=> !ft_reg)
    else $error("ft kept on power fail");
  a_alarm_wins: assert property (
    i_alarm_irq |=> o_irq_test_oe)
    else $error("alarm lost on pin");
  a_wdirq_wins: assert property (
    wd_irq_reg |=> o_irq_test_oe)
    else $error("watchdog lost on pin");
  a_ft_denied: assert property (
    !wd_reg[WD_STEER_BIT] && wd_reg != 8'h00 && !wd_irq_reg
      && !i_alarm_irq |=> !o_irq_test_oe)
    else $error("test output not denied");
  a_flag_snap: assert property (
    rd_flags && i_bus.addr == last_addr_reg
      |=> o_rdata == $past(flags_snap_reg))
    else $error("flags not from snapshot");
  a_flag_fresh: assert property (
    rd_flags && i_bus.addr != last_addr_reg
      |=> o_rdata[7] == $past(wdf_reg))
    else $error("flags not fresh");
  a_rd_idle: assert property (
    !i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  a_sqw_hiz: assert property (
    rate_reg == 4'h0 |=> !o_square_wave_oe)
    else $error("sqw not high impedance");
  a_sqw_off: assert property (
    !square_wave_enable_reg |=> !o_square_wave_oe)
    else $error("sqw on");
  a_sqw_on: assert property (
    square_wave_enable_reg && rate_reg != 4'h0 |=> o_square_wave_oe)
    else $error("sqw off");
  a_pf_reset: assert property (
    i_power_fail |=> o_reset_oe)
    else $error("power fail reset missing");
  a_no_reset: assert property (
    slow_cnt_reg < 32'(SLOW_CYC) && fast_cnt_reg < 32'(FAST_RST_CYC)
      && !i_power_fail && !o_reset_oe && !timeout |=> !o_reset_oe)
    else $error("spurious reset");
  a_fast_rst: assert property (
    !i_fast_reset_input_n [*4] |=> ##1 o_reset_oe)
    else $error("fast reset late");
  a_slow_rst: assert property (
    !i_slow_reset_input_n && slow_cnt_reg == 32'(SLOW_CYC - 1)
      |=> ##1 o_reset_oe)
    else $error("slow reset late");
  a_rec_hold: assert property (
    rst_req |=> o_reset_oe [*8])
    else $error("reset hold too short");
  a_cal_fast: assert property (
    cal_active && ctrl_reg[CAL_SIGN_BIT] |-> sec_len < 17'(OSC_HZ))
    else $error("positive calibration wrong");
  a_cal_slow: assert property (
    cal_active && !ctrl_reg[CAL_SIGN_BIT] |-> sec_len > 17'(OSC_HZ))
    else $error("negative calibration wrong");
  a_tick_width: assert property (
    o_second_tick |=> !o_second_tick)
    else $error("second tick too long");
  a_cal_none: assert property (
    ctrl_reg[4:0] == 5'h00 |-> sec_len == 17'(OSC_HZ))
    else $error("correction without magnitude");
  a_cal_late: assert property (
    min_cnt_reg >= 6'(CAL_LAST_MIN) |-> sec_len == 17'(OSC_HZ))
    else $error("correction past window");
  a_test_halt: assert property (
    st_reg && !wd_irq_reg && !i_alarm_irq |=> !o_irq_test_oe)
    else $error("test pin with halted oscillator");
  a_test_afe: assert property (
    afe_reg && !wd_irq_reg && !i_alarm_irq |=> !o_irq_test_oe)
    else $error("test pin with alarm enable");
  a_test_rate: assert property (
    !st_reg && ft_reg && !afe_reg && wd_reg == 8'h00 && !wd_irq_reg
      && !i_alarm_irq |=> o_irq_test_oe == !$past(osc_cnt_reg[5]))
    else $error("test pin not raw rate");
endmodule // sws_top

// *** bench/sws_host.sv ***
`timescale 1ns/10ps
module sws_host (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  output sws_pkg::sws_bus_type o_bus
);
  import sws_pkg::*;
  initial begin
    o_bus = '0;
  end
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    o_bus.wr <= 1'b0;
  endtask
  // Data is valid only in the cycle after the strobe
  task automatic rd(input logic [18:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    o_bus.rd <= 1'b0;
    @(posedge i_sys_clk);
    d = i_rdata;
  endtask
endmodule // sws_host

// *** bench/sws_top_tb.sv ***
`timescale 1ns/10ps
module sws_top_tb;
  import sws_pkg::*;
  logic i_sys_clk, i_rst, pfail, al_irq, al_flag, bat_low;
  logic kick, fast_n, slow_n, irq_oe, rst_oe, square_wave_pin, sqw_oe;
  sws_bus_type bus;
  logic [7:0] rdata, d;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  logic [18:0] r_a [5] = '{CTRL_ADDR, CTRL_ADDR, FLAGS_ADDR, WD_ADDR,
    19'h7FFF1};
  logic [7:0] r_w [5] = '{8'h25, 8'h1F, 8'h05, 8'h00, 8'hAA};
  logic [7:0] r_e [5] = '{8'h25, 8'h1F, 8'h05, 8'h00, 8'h00};
  sws_top #(.SLOW_CYC(20), .REC_CYC_P(30), .SIXTEENTH_OSC(2)) sws_top_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus(bus),
    .i_power_fail(pfail), .i_alarm_irq(al_irq), .i_alarm_flag(al_flag),
    .i_battery_low(bat_low), .i_watchdog_kick_input(kick),
    .i_fast_reset_input_n(fast_n), .i_slow_reset_input_n(slow_n),
    .o_rdata(rdata), .o_irq_test_oe(irq_oe), .o_reset_oe(rst_oe),
    .o_square_wave_pin(square_wave_pin), .o_square_wave_oe(sqw_oe), .o_second_tick());
  sws_host sws_host_i (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_bus(bus));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waits for a pin level within lim cycles, n keeps the count
  task automatic wt(input int s, input logic v, input int lim, string nm);
    for (n = 0; n < lim; n++) begin
      if ((s == 0 ? rst_oe : s == 1 ? irq_oe : square_wave_pin) === v) break;
      @(posedge i_sys_clk);
    end
    chk(nm, 8'(n < lim), 8'h01);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic flags_wdf(input logic [7:0] e, string nm);
    sws_host_i.rd(FLAGS_ADDR, d);
    chk(nm, d & 8'h80, e);
  endtask
  initial begin
    i_sys_clk = 0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #1900000;
    bad_count++;
    final_report();
  end
  initial begin
    i_rst = 1; pfail = 0; al_irq = 0; al_flag = 0; bat_low = 0;
    kick = 0; fast_n = 1; slow_n = 1;
    repeat (10) @(posedge i_sys_clk);
    chk("rst in reset", 8'(rst_oe), 8'h00);
    i_rst <= 0;
    for (int i = 0; i < 5; i++) begin
      sws_host_i.wr(r_a[i], r_w[i]);
      sws_host_i.rd(19'h7FFF1, d);
      sws_host_i.rd(r_a[i], d);
      chk("row read", d, r_e[i]);
    end
    $display("register rows done");
    sws_host_i.wr(WD_ADDR, 8'h08);
    wt(1, 1, 7000, "wd irq");
    chk("no reset", 8'(rst_oe), 8'h00);
    sws_host_i.rd(19'h7FFF1, d);
    flags_wdf(8'h80, "wdf set");
    flags_wdf(8'h80, "wdf snapshot");
    sws_host_i.rd(19'h7FFF1, d);
    flags_wdf(8'h00, "wdf clear");
    chk("irq held", 8'(irq_oe), 8'h01);
    sws_host_i.wr(WD_ADDR, 8'h00);
    wt(1, 0, 4, "irq release");
    $display("watchdog irq done");
    sws_host_i.wr(WD_ADDR, 8'h08);
    for (int k = 0; k < 12; k++) begin
      repeat (500) @(posedge i_sys_clk);
      if (k[0]) kick <= ~kick;
      else sws_host_i.wr(WD_ADDR, 8'h08);
    end
    chk("kicked", 8'(irq_oe), 8'h00);
    wt(1, 1, 7000, "wd after kicks");
    sws_host_i.wr(WD_ADDR, 8'h00);
    $display("watchdog restart done");
    sws_host_i.wr(FLAGS_ADDR, 8'h01);
    sws_host_i.wr(ALARM_MON_ADDR, 8'hE0);
    sws_host_i.wr(DAY_ADDR, 8'h40);
    repeat (3) @(posedge i_sys_clk);
    chk("sqw on", 8'(sqw_oe), 8'h01);
    wt(2, ~square_wave_pin, 2000, "sqw toggle");
    sws_host_i.wr(FLAGS_ADDR, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    chk("sqw hiz", 8'(sqw_oe), 8'h00);
    sws_host_i.wr(FLAGS_ADDR, 8'h01);
    sws_host_i.wr(WD_ADDR, 8'h88);
    wt(0, 1, 7000, "wd reset");
    wt(0, 0, 200, "wd reset end");
    chk("wd pulse len", 8'(n >= 28), 8'h01);
    sws_host_i.rd(WD_ADDR, d);
    chk("wd cleared", d, 8'h00);
    chk("square_wave_enable cleared", 8'(sqw_oe), 8'h00);
    $display("watchdog reset done");
    sws_host_i.wr(DAY_ADDR, 8'h40);
    al_irq <= 1;
    wt(1, 1, 4, "alarm wins");
    sws_host_i.wr(DAY_ADDR, 8'h00);
    al_irq <= 0;
    wt(1, 0, 4, "alarm off");
    $display("pin precedence done");
    fast_n <= 0;
    @(posedge i_sys_clk);
    fast_n <= 1;
    repeat (20) @(posedge i_sys_clk);
    chk("fast glitch", 8'(rst_oe), 8'h00);
    fast_n <= 0;
    wt(0, 1, 11, "fast assert");
    repeat (5) @(posedge i_sys_clk);
    fast_n <= 1;
    wt(0, 0, 200, "fast release");
    chk("fast hold", 8'(n >= 28), 8'h01);
    slow_n <= 0;
    repeat (5) @(posedge i_sys_clk);
    slow_n <= 1;
    repeat (30) @(posedge i_sys_clk);
    chk("slow glitch", 8'(rst_oe), 8'h00);
    slow_n <= 0;
    wt(0, 1, 101, "slow assert");
    chk("slow filter", 8'(n >= 18), 8'h01);
    slow_n <= 1;
    wt(0, 0, 200, "slow release");
    chk("slow hold", 8'(n >= 28), 8'h01);
    $display("reset inputs done");
    sws_host_i.wr(WD_ADDR, 8'h08);
    pfail <= 1;
    wt(0, 1, 5, "pf assert");
    repeat (10) @(posedge i_sys_clk);
    pfail <= 0;
    wt(0, 0, 200, "pf release");
    chk("pf hold", 8'(n >= 28), 8'h01);
    sws_host_i.rd(WD_ADDR, d);
    chk("wd after pf", d, 8'h00);
    $display("power fail done");
    final_report();
  end
endmodule // sws_top_tb
